// >>> serial_eeprom_defines.vh
`ifndef SERIAL_EEPROM_DEFINES_VH
`define SERIAL_EEPROM_DEFINES_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define MCLK_MHZ 40
`define PROG_TIME_US 5000
`define PROG_CYCLES (`PROG_TIME_US * `MCLK_MHZ)
`define OUT_DELAY_MAX_NS 150
`define OUT_DELAY_CYCLES (`OUT_DELAY_MAX_NS / 25)

// ----------------------------------------
// instruction format
// ----------------------------------------
`define CMD_BITS_X16 4'hc
`define CMD_BITS_X8 4'hd
`define DATA_BITS_X16 5'h10
`define DATA_BITS_X8 5'h08
`define OPC_EXT 2'h0
`define OPC_WRITE 2'h1
`define OPC_READ 2'h2
`define OPC_ERASE 2'h3
`define EXT_LOCK 2'h0
`define EXT_FILL 2'h1
`define EXT_CLEAR 2'h2
`define EXT_UNLOCK 2'h3

// ----------------------------------------
// self-timed operation codes
// ----------------------------------------
`define OP_ERASE 2'h0
`define OP_WRITE 2'h1
`define OP_CLEAR_ALL 2'h2
`define OP_FILL_ALL 2'h3

`define LAST_WORD 10'h3ff

`endif

// >>> serial_eeprom_command_port.v
`timescale 1ns/1ps
`include "serial_eeprom_defines.vh"
`default_nettype none

module serial_eeprom_command_port #(
  parameter [31:0] PROG_CYCLES = `PROG_CYCLES
) (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // serial pins
  input wire chip_select,
  input wire serial_clk_in,
  input wire serial_in,
  output reg serial_out,
  output reg serial_out_oe,
  // straps
  input wire word_width_select,
  input wire program_permit,
  // state
  output wire busy
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CMD = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_READ = 3'h3;
  localparam [2:0] ST_HOLD = 3'h4;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg rst_s1_r;
  reg rst_n_r;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  reg [15:0] mem [0:1023];
  reg [2:0] state_r;
  reg sk_r;
  reg [12:0] cmd_r;
  reg [3:0] cnt_r;
  reg [4:0] dcnt_r;
  reg [15:0] wdata_r;
  reg [15:0] rbuf_r;
  reg [10:0] addr_r;
  reg pend_r;
  reg [1:0] op_r;
  reg wel_r;
  reg status_en_r;
  reg release_r;
  reg busy_r;
  reg [31:0] timer_r;
  reg sweep_on_r;
  reg [9:0] idx_r;
  reg bytemode_r;
  reg bytesel_r;

  assign busy = busy_r;

  wire x16 = word_width_select;
  wire sk_rise = serial_clk_in & ~sk_r;
  wire sk_fall = ~serial_clk_in & sk_r;
  wire [3:0] cmd_len = x16 ? `CMD_BITS_X16 : `CMD_BITS_X8;
  wire [4:0] data_len = x16 ? `DATA_BITS_X16 : `DATA_BITS_X8;

  // decode of the fully shifted instruction, new bit included
  wire [12:0] cmd_full = {cmd_r[11:0], serial_in};
  wire [1:0] opc = x16 ? cmd_full[11:10] : cmd_full[12:11];
  wire [1:0] ext = x16 ? cmd_full[9:8] : cmd_full[10:9];
  wire [10:0] addr_in = x16 ? {1'b0, cmd_full[9:0]} : cmd_full[10:0];
  wire prog_ok = wel_r & program_permit;

  // read word lookup; bytes of a word: odd byte address is the high byte
  function [15:0] rd_word;
    input [10:0] a;
    input wide;
    reg [15:0] w;
    begin
      w = mem[wide ? a[9:0] : a[10:1]];
      if (wide)
        rd_word = w;
      else
        rd_word = {(a[0] ? w[15:8] : w[7:0]), 8'h00};
    end
  endfunction

  wire [10:0] addr_next = x16 ? {1'b0, addr_r[9:0] + 10'h001} : addr_r + 11'h001;

  // ----------------------------------------
  // self-timed write value
  // ----------------------------------------
  wire erase_op = (op_r == `OP_ERASE) | (op_r == `OP_CLEAR_ALL);
  wire all_op = op_r[1];
  wire [15:0] old_word = mem[idx_r];
  wire [7:0] new_byte = erase_op ? 8'hff : wdata_r[7:0];
  reg [15:0] new_word;
  always @* begin
    if (!bytemode_r)
      new_word = erase_op ? 16'hffff : wdata_r;
    else if (all_op)
      new_word = {new_byte, new_byte};
    else if (bytesel_r)
      new_word = {new_byte, old_word[7:0]};
    else
      new_word = {old_word[15:8], new_byte};
  end

  // whole location overwritten in one step, so no erase beforehand is needed
  always @(posedge mclk) begin
    if (sweep_on_r)
      mem[idx_r] <= new_word;
  end

  // ----------------------------------------
  // command engine
  // ----------------------------------------
  always @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
      sk_r <= 1'b0;
      cmd_r <= 13'h0000;
      cnt_r <= 4'h0;
      dcnt_r <= 5'h00;
      wdata_r <= 16'h0000;
      rbuf_r <= 16'h0000;
      addr_r <= 11'h000;
      pend_r <= 1'b0;
      op_r <= 2'h0;
      wel_r <= 1'b0;
      status_en_r <= 1'b0;
      release_r <= 1'b0;
      busy_r <= 1'b0;
      timer_r <= 32'h00000000;
      sweep_on_r <= 1'b0;
      idx_r <= 10'h000;
      bytemode_r <= 1'b0;
      bytesel_r <= 1'b0;
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      sk_r <= serial_clk_in;

      // programming timer runs without serial clocks
      if (busy_r) begin
        if (timer_r <= 32'h00000001)
          busy_r <= 1'b0;
        timer_r <= timer_r - 32'h00000001;
      end
      if (sweep_on_r) begin
        if (all_op && idx_r != `LAST_WORD) begin
          idx_r <= idx_r + 10'h001;
        end else begin
          sweep_on_r <= 1'b0;
        end
      end

      if (!chip_select) begin
        // deselect: abort partial instruction, start pending program
        serial_out_oe <= 1'b0;
        release_r <= 1'b0;
        state_r <= ST_IDLE;
        pend_r <= 1'b0;
        if (state_r == ST_HOLD && pend_r) begin
          busy_r <= 1'b1;
          timer_r <= PROG_CYCLES;
          sweep_on_r <= 1'b1;
          idx_r <= op_r[1] ? 10'h000 : (bytemode_r ? addr_r[10:1] : addr_r[9:0]);
          status_en_r <= 1'b1;
        end
      end else begin
        case (state_r)
          ST_IDLE: begin
            // status shows while a program cycle is or was running
            serial_out_oe <= status_en_r;
            serial_out <= ~busy_r;
            if (sk_rise && serial_in) begin
              if (status_en_r)
                release_r <= 1'b1;
              // a busy device takes the one as status release only
              if (!busy_r) begin
                state_r <= ST_CMD;
                cnt_r <= 4'h0;
              end
            end
          end
          ST_CMD: begin
            if (sk_rise) begin
              cmd_r <= cmd_full;
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r + 4'h1 == cmd_len) begin
                addr_r <= addr_in;
                bytemode_r <= ~x16;
                bytesel_r <= addr_in[0];
                dcnt_r <= 5'h00;
                state_r <= ST_HOLD;
                if (opc == `OPC_READ) begin
                  state_r <= ST_READ;
                  serial_out_oe <= 1'b1;
                  serial_out <= 1'b0;
                  rbuf_r <= rd_word(addr_in, x16);
                  dcnt_r <= data_len;
                end else if (opc == `OPC_ERASE) begin
                  op_r <= `OP_ERASE;
                  pend_r <= prog_ok;
                end else if (opc == `OPC_WRITE) begin
                  op_r <= `OP_WRITE;
                  state_r <= ST_DATA;
                end else if (ext == `EXT_UNLOCK) begin
                  wel_r <= 1'b1;
                end else if (ext == `EXT_LOCK) begin
                  wel_r <= 1'b0;
                end else if (ext == `EXT_CLEAR) begin
                  op_r <= `OP_CLEAR_ALL;
                  pend_r <= prog_ok;
                end else begin
                  op_r <= `OP_FILL_ALL;
                  state_r <= ST_DATA;
                end
              end
            end
          end
          ST_DATA: begin
            if (sk_rise) begin
              wdata_r <= x16 ? {wdata_r[14:0], serial_in} : {8'h00, wdata_r[6:0], serial_in};
              dcnt_r <= dcnt_r + 5'h01;
              if (dcnt_r + 5'h01 == data_len) begin
                state_r <= ST_HOLD;
                pend_r <= prog_ok;
              end
            end
          end
          ST_READ: begin
            if (sk_rise) begin
              serial_out <= rbuf_r[15];
              if (dcnt_r == 5'h01) begin
                addr_r <= addr_next;
                rbuf_r <= rd_word(addr_next, x16);
                dcnt_r <= data_len;
              end else begin
                rbuf_r <= {rbuf_r[14:0], 1'b0};
                dcnt_r <= dcnt_r - 5'h01;
              end
            end
          end
          default: begin
            // complete instruction; extra clocks ignored until deselect
            serial_out_oe <= 1'b0;
          end
        endcase
        if (release_r && sk_fall) begin
          status_en_r <= 1'b0;
          release_r <= 1'b0;
          serial_out_oe <= 1'b0;
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> eeprom_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// pin checker
// ----
module eeprom_monitor #(
  parameter [31:0] PROG_CYCLES = 32'h3e8
) (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // pins
  input wire chip_select,
  input wire serial_clk_in,
  input wire serial_in,
  input wire serial_out,
  input wire serial_out_oe,
  input wire word_width_select,
  input wire program_permit,
  input wire busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // busy length counted here, a 1000-deep repetition would not unroll
  reg [31:0] cnt_r;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) cnt_r <= 32'h0;
    else cnt_r <= busy ? cnt_r + 32'h1 : 32'h0;
  end
  reset_quiet_a: assert property ($rose(arst_n) |-> !serial_out_oe && !busy)
    else $error("outputs active after reset");
  busy_cause_a: assert property ($rose(busy) |-> !$past(chip_select))
    else $error("program start while selected");
  busy_hold_a: assert property ($rose(busy) |-> busy [*8])
    else $error("program cycle cut short");
  busy_bound_a: assert property (cnt_r <= PROG_CYCLES)
    else $error("program cycle too long");
  status_low_a: assert property (busy && $past(busy) && chip_select && serial_out_oe |-> !serial_out)
    else $error("ready shown while busy");
  out_edge_a: assert property ($changed(serial_out) && serial_out_oe && $past(serial_out_oe) && !busy
    && !$past(busy) && !$past(busy, 2) |-> serial_clk_in && !$past(serial_clk_in, 3))
    else $error("read bit moved off a clock rise");
  release_fall_a: assert property ($fell(serial_out_oe) && chip_select |-> !serial_clk_in)
    else $error("release not on falling clock");
  read_drive_a: assert property ($rose(serial_out_oe) && $past(chip_select, 2) && !busy |-> serial_clk_in)
    else $error("read drive not on a rise");
  cover property ($rose(busy));
  cover property ($fell(serial_out_oe) && chip_select);
  cover property ($rose(serial_out_oe) && !busy);
endmodule
bind serial_eeprom_command_port eeprom_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_mon (.mclk, .arst_n,
  .chip_select, .serial_clk_in, .serial_in, .serial_out, .serial_out_oe, .word_width_select,
  .program_permit, .busy);
`default_nettype wire

// >>> eeprom_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// host side of the link
// ----
module eeprom_host (
  // clock
  input wire mclk,
  // pins
  input wire serial_out,
  output logic chip_select,
  output logic serial_clk_in,
  output logic serial_in
);
  initial begin
    chip_select = 1'b0;
    serial_clk_in = 1'b0;
    serial_in = 1'b0;
  end
  task sel;
    @(negedge mclk) chip_select = 1'b1;
  endtask
  // deselect held well past the minimum low time
  task desel;
    begin
      @(negedge mclk) chip_select = 1'b0;
      repeat (8) @(negedge mclk);
    end
  endtask
  // msb first, serial clock idles low between frames
  task automatic bits(input [63:0] v, input integer n, output [63:0] q);
    integer i;
    begin
      q = 64'h0;
      for (i = n - 1; i >= 0; i = i - 1) begin
        @(negedge mclk) serial_clk_in = 1'b0;
        serial_in = v[i];
        repeat (2) @(negedge mclk);
        serial_clk_in = 1'b1;
        repeat (3) @(negedge mclk);
        q = {q[62:0], serial_out};
      end
      @(negedge mclk) serial_clk_in = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----
  // bench
  // ----
  localparam [31:0] PC = 32'h44c;
  logic mclk, arst_n, word_width_select, program_permit;
  wire chip_select, serial_clk_in, serial_in, serial_out, serial_out_oe, busy;
  // released line reads inverted, so a sample taken off the drive shows up
  wire do_line = serial_out_oe ? serial_out : ~serial_out;
  integer n_fail = 0, samples_checked = 0, seed = 4, cyc = 0, k;
  logic [63:0] q;
  logic [15:0] d0, d1, d2, d3;
  serial_eeprom_command_port #(.PROG_CYCLES(PC)) i_dut (.mclk, .arst_n, .chip_select, .serial_clk_in,
    .serial_in, .serial_out, .serial_out_oe, .word_width_select, .program_permit, .busy);
  eeprom_host i_host (.mclk, .serial_out(do_line), .chip_select, .serial_clk_in, .serial_in);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // sequence needs about 12k cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("checks %0d fails %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [63:0] s, input [63:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task prog(input [63:0] v, input integer n, input eb);
    begin
      i_host.sel;
      i_host.bits(v, n, q);
      i_host.desel;
      chk("busy", 64'(busy), 64'(eb));
      for (k = 0; k < 3000 && busy !== 1'b0; k = k + 1) @(negedge mclk);
    end
  endtask
  // three idle zeros lead every read
  task rd(input [13:0] v, input integer len, input integer n);
    begin
      i_host.sel;
      i_host.bits(64'(v) << n, len + n + 3, q);
      i_host.desel;
    end
  endtask
  initial begin
    arst_n = 1'b0;
    word_width_select = 1'b1;
    program_permit = 1'b0;
    {d0, d1} = $random(seed);
    {d2, d3} = $random(seed);
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    prog(64'h1300, 13, 1'b0);
    prog({35'h0, 3'b101, 10'h000, d1}, 29, 1'b0);
    program_permit = 1'b1;
    prog({35'h0, 3'b101, 10'h000, d1}, 29, 1'b1);
    i_host.sel;
    i_host.bits({35'h0, 3'b101, 10'h3ff, d0}, 29, q);
    i_host.desel;
    i_host.sel;
    repeat (4) @(negedge mclk);
    chk("oe", 64'(serial_out_oe), 64'h1);
    chk("status", 64'(serial_out), 64'h0);
    for (k = 0; k < 3000 && busy !== 1'b0; k = k + 1) @(negedge mclk);
    repeat (4) @(negedge mclk);
    chk("ready", 64'(serial_out), 64'h1);
    i_host.bits(64'h1, 1, q);
    repeat (4) @(negedge mclk);
    chk("oe", 64'(serial_out_oe), 64'h0);
    i_host.desel;
    $display("write and status done");
    rd({4'b0110, 10'h3ff}, 13, 32);
    chk("dummy", 64'(q[32]), 64'h0);
    chk("seq", 64'(q[31:0]), {32'h0, d0, d1});
    word_width_select = 1'b0;
    rd({3'b110, 11'h001}, 14, 8);
    chk("byte", 64'(q[8:0]), 64'(d1[15:8]));
    word_width_select = 1'b1;
    $display("read done");
    prog({51'h0, 3'b111, 10'h3ff}, 13, 1'b1);
    rd({4'b0110, 10'h3ff}, 13, 16);
    chk("erased", 64'(q[16:0]), 64'hffff);
    prog({35'h0, 3'b101, 10'h000, d2}, 29, 1'b1);
    i_host.sel;
    i_host.bits({43'h0, 3'b101, 10'h000, 8'h5a}, 21, q);
    i_host.desel;
    chk("abort", 64'(busy), 64'h0);
    prog(64'h1000, 13, 1'b0);
    prog({35'h0, 3'b101, 10'h000, ~d2}, 29, 1'b0);
    rd({4'b0110, 10'h000}, 13, 16);
    chk("kept", 64'(q[16:0]), 64'(d2));
    $display("erase and lock done");
    prog(64'h1300, 13, 1'b0);
    prog({35'h0, 13'h1100, d3}, 29, 1'b1);
    rd({4'b0110, 10'h3ff}, 13, 32);
    chk("fill", 64'(q[31:0]), {32'h0, d3, d3});
    prog(64'h1200, 13, 1'b1);
    rd({4'b0110, 10'h155}, 13, 16);
    chk("clear", 64'(q[16:0]), 64'hffff);
    $display("array ops done");
    word_width_select = 1'b0;
    prog({42'h0, 3'b101, 11'h002, d0[7:0]}, 22, 1'b1);
    word_width_select = 1'b1;
    rd({4'b0110, 10'h001}, 13, 16);
    chk("byte write", 64'(q[16:0]), {48'h0, 8'hff, d0[7:0]});
    arst_n = 1'b0;
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    prog({35'h0, 3'b101, 10'h001, ~d0}, 29, 1'b0);
    rd({4'b0110, 10'h001}, 13, 16);
    chk("reset lock", 64'(q[16:0]), {48'h0, 8'hff, d0[7:0]});
    $display("byte write and reset done");
    report_and_stop;
  end
endmodule
`default_nettype wire
